// [verilog/lld_map.vh]
/*
 * Constants for the load/loop opcode decode slice: opcode bytes,
 * reg-field selectors, clock counts and instruction class codes.
 * Assumes plain Verilog-2005 inclusion by bare file name.
 */
`ifndef LLD_MAP_VH
`define LLD_MAP_VH

// opcode bytes
`define LLD_OP_ESC          8'h0F
`define LLD_OP_FLAGS_AH     8'h9F
`define LLD_OP_EA_CALC      8'h8D
`define LLD_OP_FAR_ES       8'hC4
`define LLD_OP_FRAME_LEAVE  8'hC9
`define LLD_OP_LOOP         8'hE2
`define LLD_OP_LOOP_NZ      8'hE0
`define LLD_OP_LOOP_Z       8'hE1
`define LLD_OP_JSIGN8       8'h78
`define LLD_OP_MOVE_LO      8'h88
`define LLD_OP_MOVE_HI      8'h8B
// second bytes after the escape
`define LLD_OP2_GRP0        8'h00
`define LLD_OP2_GRP1        8'h01
`define LLD_OP2_ACC_RIGHTS  8'h02
`define LLD_OP2_SEG_LIMIT   8'h03
`define LLD_OP2_FAR_FS      8'hB4
`define LLD_OP2_FAR_GS      8'hB5
`define LLD_OP2_FAR_SS      8'hB2
`define LLD_OP2_JSIGN       8'h88
`define LLD_OP2_JPAR        8'h8A
// modrm reg field selectors and the mod field register value
`define LLD_REG_GDT         3'h2
`define LLD_REG_IDT         3'h3
`define LLD_REG_MSW         3'h6
`define LLD_REG_LDT         3'h2
`define LLD_REG_TASK        3'h3
`define LLD_MOD_REG         2'h3

// clock counts on a cache hit
`define LLD_CLK_FLAGS_AH    5'h02
`define LLD_CLK_ACC_RIGHTS  5'h09
`define LLD_CLK_EA_CALC     5'h01
`define LLD_CLK_FAR_REAL    5'h04
`define LLD_CLK_FAR_PROT    5'h09
`define LLD_CLK_SS_PROT     5'h0A
`define LLD_CLK_DESC_TBL    5'h0A
`define LLD_CLK_MSW         5'h0B
`define LLD_CLK_LDT         5'h08
`define LLD_CLK_TASK        5'h09
`define LLD_CLK_SEG_LIMIT   5'h09
`define LLD_CLK_LEAVE       5'h04
`define LLD_CLK_LOOP        5'h02
`define LLD_CLK_JUMP        5'h01
`define LLD_CLK_MOVE        5'h01
`define LLD_CLK_FAULT       5'h01

// instruction class codes
`define LLD_CLS_NONE        5'h00
`define LLD_CLS_FLAGS_AH    5'h01
`define LLD_CLS_ACC_RIGHTS  5'h02
`define LLD_CLS_EA_CALC     5'h03
`define LLD_CLS_FAR_ES      5'h04
`define LLD_CLS_FAR_FS      5'h05
`define LLD_CLS_FAR_GS      5'h06
`define LLD_CLS_FAR_SS      5'h07
`define LLD_CLS_GDT         5'h08
`define LLD_CLS_IDT         5'h09
`define LLD_CLS_MSW         5'h0A
`define LLD_CLS_LDT         5'h0B
`define LLD_CLS_TASK        5'h0C
`define LLD_CLS_SEG_LIMIT   5'h0D
`define LLD_CLS_LEAVE       5'h0E
`define LLD_CLS_LOOP        5'h0F
`define LLD_CLS_LOOP_NZ     5'h10
`define LLD_CLS_LOOP_Z      5'h11
`define LLD_CLS_JSIGN       5'h12
`define LLD_CLS_JPAR        5'h13
`define LLD_CLS_MOVE_RR     5'h14
`define LLD_CLS_MOVE_MEM    5'h15

// flag update mask bits
`define LLD_FLAG_NONE       1'b0
`define LLD_FLAG_ZF         1'b1

`endif

// [verilog/lld_busy_count.v]
/*
 * Down counter that holds the decoder busy for an instruction's
 * clock count. Assumes load is only pulsed while idle.
 */
`timescale 1ns/1ps
module lld_busy_count (
	input  wire       mclk,
	input  wire       reset_n,
	input  wire       load,
	input  wire [4:0] count,
	output wire       busy
);
	reg [4:0] cnt_q;
	reg [4:0] cnt_d;

	always @* begin
		cnt_d = cnt_q;
		if (load)
			cnt_d = count - 5'h01;
		else if (cnt_q != 5'h00)
			cnt_d = cnt_q - 5'h01;
	end

	always @(posedge mclk) begin
		if (!reset_n)
			cnt_q <= 5'h00;
		else
			cnt_q <= cnt_d;
	end

	assign busy = (cnt_q != 5'h00);
endmodule

// [verilog/lld_decode.v]
/*
 * Decode and timing slice for flag transfer, descriptor loads,
 * far-pointer loads, frame leave, counted loops, sign/parity jumps
 * and register moves. Assumes instruction bytes arrive from logic on
 * the same clock, one instruction per valid pulse, with the escape and
 * ModR/M bytes already gathered by the fetch stage.
 * An instruction is taken on an edge where instr_valid is high and no
 * earlier instruction still owes clocks; an offer made while busy is
 * dropped and must be presented again once ready is high. ready and
 * busy are registered for the coming cycle, so ready high means that
 * the next edge takes. The decode result holds until the next take,
 * while dec_valid, zf_update and invalid_op pulse for one cycle.
 * Unknown forms still pulse dec_valid, with class none and no clocks.
 */
`timescale 1ns/1ps
`include "lld_map.vh"

// Functional notes
// - 9F copies flags to AH, 2 clocks
// - 0F 02 access-rights load, protected only, 9
// - 8D effective address, 1 clock, no flags
// - C4 far load extra segment, 4/9
// - 0F B4 far load F segment, 4/9
// - 0F B5 far load G segment, 4/9
// - 0F B2 far load stack segment, 4/10
// - 0F 01 reg 010 global table, 10
// - 0F 01 reg 011 interrupt table, 10
// - 0F 01 reg 110 status word, 11
// - 0F 00 reg 010 local table, protected, 8
// - 0F 00 reg 011 task register, protected, 9
// - 0F 03 segment limit, protected, 9, ZF
// - C9 frame teardown, 4 clocks
// - E2/E0/E1 counted loops, 2 clocks, no flags
module lld_decode (
	input  wire       mclk,
	input  wire       reset_n,
	input  wire       instr_valid,
	input  wire       two_byte,
	input  wire [7:0] opcode,
	input  wire [7:0] modrm,
	input  wire       prot_mode,
	output reg        ready,
	output reg        dec_valid,
	output reg  [4:0] dec_class,
	output reg  [4:0] dec_clocks,
	output reg        zf_update,
	output reg        invalid_op,
	output reg        busy
);
	reg  [4:0] cls_d;
	reg  [4:0] clk_real;
	reg  [4:0] clk_prot;
	reg        prot_only;
	reg        zf_d;
	reg  [4:0] clk_sel;
	reg        fault_d;
	wire [2:0] reg_f;
	wire [1:0] mod_f;
	wire       take;
	wire       cnt_busy;
	wire       cnt_more;
	wire       load_main;
	wire       multi;
	wire [4:0] count_next;
	reg        busy_next;

	// modrm fields; forms without a modrm byte ignore them
	assign reg_f = modrm[5:3];
	assign mod_f = modrm[7:6];
	assign take  = instr_valid && !cnt_busy;
	assign load_main  = take && (clk_sel != 5'h00);
	assign multi      = take && (clk_sel > 5'h01);
	assign count_next = clk_sel - 5'h01;

	////////////////////////////////////////////////////////////////////
	// opcode classification
	// one-byte forms first, then the forms that follow the escape byte
	always @* begin
		cls_d     = `LLD_CLS_NONE;
		clk_real  = 5'h00;
		clk_prot  = 5'h00;
		prot_only = 1'b0;
		zf_d      = `LLD_FLAG_NONE;
		if (!two_byte) begin
			case (opcode)
			`LLD_OP_FLAGS_AH: begin
				cls_d    = `LLD_CLS_FLAGS_AH;
				clk_real = `LLD_CLK_FLAGS_AH;
				clk_prot = `LLD_CLK_FLAGS_AH;
			end
			`LLD_OP_EA_CALC: begin
				cls_d    = `LLD_CLS_EA_CALC;
				clk_real = `LLD_CLK_EA_CALC;
				clk_prot = `LLD_CLK_EA_CALC;
			end
			`LLD_OP_FAR_ES: begin
				cls_d    = `LLD_CLS_FAR_ES;
				clk_real = `LLD_CLK_FAR_REAL;
				clk_prot = `LLD_CLK_FAR_PROT;
			end
			`LLD_OP_FRAME_LEAVE: begin
				cls_d    = `LLD_CLS_LEAVE;
				clk_real = `LLD_CLK_LEAVE;
				clk_prot = `LLD_CLK_LEAVE;
			end
			`LLD_OP_LOOP: begin
				cls_d    = `LLD_CLS_LOOP;
				clk_real = `LLD_CLK_LOOP;
				clk_prot = `LLD_CLK_LOOP;
			end
			`LLD_OP_LOOP_NZ: begin
				cls_d    = `LLD_CLS_LOOP_NZ;
				clk_real = `LLD_CLK_LOOP;
				clk_prot = `LLD_CLK_LOOP;
			end
			`LLD_OP_LOOP_Z: begin
				cls_d    = `LLD_CLS_LOOP_Z;
				clk_real = `LLD_CLK_LOOP;
				clk_prot = `LLD_CLK_LOOP;
			end
			`LLD_OP_JSIGN8: begin
				cls_d    = `LLD_CLS_JSIGN;
				clk_real = `LLD_CLK_JUMP;
				clk_prot = `LLD_CLK_JUMP;
			end
			default: begin
				if (opcode >= `LLD_OP_MOVE_LO && opcode <= `LLD_OP_MOVE_HI) begin
					// register form when mod selects a register
					cls_d    = (mod_f == `LLD_MOD_REG) ? `LLD_CLS_MOVE_RR
						: `LLD_CLS_MOVE_MEM;
					clk_real = `LLD_CLK_MOVE;
					clk_prot = `LLD_CLK_MOVE;
				end
			end
			endcase
		end else begin
			case (opcode)
			`LLD_OP2_ACC_RIGHTS: begin
				cls_d     = `LLD_CLS_ACC_RIGHTS;
				clk_prot  = `LLD_CLK_ACC_RIGHTS;
				prot_only = 1'b1;
				zf_d      = `LLD_FLAG_ZF;
			end
			`LLD_OP2_SEG_LIMIT: begin
				cls_d     = `LLD_CLS_SEG_LIMIT;
				clk_prot  = `LLD_CLK_SEG_LIMIT;
				prot_only = 1'b1;
				zf_d      = `LLD_FLAG_ZF;
			end
			`LLD_OP2_FAR_FS: begin
				cls_d    = `LLD_CLS_FAR_FS;
				clk_real = `LLD_CLK_FAR_REAL;
				clk_prot = `LLD_CLK_FAR_PROT;
			end
			`LLD_OP2_FAR_GS: begin
				cls_d    = `LLD_CLS_FAR_GS;
				clk_real = `LLD_CLK_FAR_REAL;
				clk_prot = `LLD_CLK_FAR_PROT;
			end
			`LLD_OP2_FAR_SS: begin
				cls_d    = `LLD_CLS_FAR_SS;
				clk_real = `LLD_CLK_FAR_REAL;
				clk_prot = `LLD_CLK_SS_PROT;
			end
			// descriptor group, chosen by the modrm reg field
			`LLD_OP2_GRP1: begin
				case (reg_f)
				`LLD_REG_GDT: begin
					cls_d    = `LLD_CLS_GDT;
					clk_real = `LLD_CLK_DESC_TBL;
					clk_prot = `LLD_CLK_DESC_TBL;
				end
				`LLD_REG_IDT: begin
					cls_d    = `LLD_CLS_IDT;
					clk_real = `LLD_CLK_DESC_TBL;
					clk_prot = `LLD_CLK_DESC_TBL;
				end
				`LLD_REG_MSW: begin
					cls_d    = `LLD_CLS_MSW;
					clk_real = `LLD_CLK_MSW;
					clk_prot = `LLD_CLK_MSW;
				end
				default: cls_d = `LLD_CLS_NONE;
				endcase
			end
			// selector group, chosen by the modrm reg field
			`LLD_OP2_GRP0: begin
				case (reg_f)
				`LLD_REG_LDT: begin
					cls_d     = `LLD_CLS_LDT;
					clk_prot  = `LLD_CLK_LDT;
					prot_only = 1'b1;
				end
				`LLD_REG_TASK: begin
					cls_d     = `LLD_CLS_TASK;
					clk_prot  = `LLD_CLK_TASK;
					prot_only = 1'b1;
				end
				default: cls_d = `LLD_CLS_NONE;
				endcase
			end
			`LLD_OP2_JSIGN: begin
				cls_d    = `LLD_CLS_JSIGN;
				clk_real = `LLD_CLK_JUMP;
				clk_prot = `LLD_CLK_JUMP;
			end
			`LLD_OP2_JPAR: begin
				cls_d    = `LLD_CLS_JPAR;
				clk_real = `LLD_CLK_JUMP;
				clk_prot = `LLD_CLK_JUMP;
			end
			default: cls_d = `LLD_CLS_NONE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// mode selection and fault
	always @* begin
		fault_d = prot_only && !prot_mode;
		clk_sel = 5'h00;
		if (fault_d) begin
			// the exception is raised in a single clock instead of the load
			clk_sel = `LLD_CLK_FAULT;
		end else if (cls_d != `LLD_CLS_NONE) begin
			if (prot_mode)
				clk_sel = clk_prot;
			else
				clk_sel = clk_real;
		end
	end

	////////////////////////////////////////////////////////////////////
	// busy counters
	lld_busy_count u_busy (
		.mclk    (mclk),
		.reset_n (reset_n),
		.load    (load_main),
		.count   (clk_sel),
		.busy    (cnt_busy)
	);

	// a second counter loaded one lower runs out a cycle earlier, so ready
	// and busy can be registered for the cycle in which the next take is possible
	lld_busy_count u_busy_next (
		.mclk    (mclk),
		.reset_n (reset_n),
		.load    (multi),
		.count   (count_next),
		.busy    (cnt_more)
	);

	always @* begin
		// busy covers the clocks still owed after the current one
		busy_next = cnt_more;
		if (multi)
			busy_next = 1'b1;
	end

	////////////////////////////////////////////////////////////////////
	// handshake status
	always @(posedge mclk) begin
		// ready is low through reset and is otherwise the inverse of busy
		if (!reset_n) begin
			ready <= 1'b0;
			busy  <= 1'b0;
		end else begin
			ready <= !busy_next;
			busy  <= busy_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// decode result, held until the next take
	always @(posedge mclk) begin
		if (!reset_n) begin
			dec_class  <= `LLD_CLS_NONE;
			dec_clocks <= 5'h00;
		end else if (take) begin
			dec_class  <= fault_d ? `LLD_CLS_NONE : cls_d;
			dec_clocks <= clk_sel;
		end
	end

	////////////////////////////////////////////////////////////////////
	// one-cycle pulses that travel with dec_valid
	always @(posedge mclk) begin
		// the exception and the flag write are reported only with a take
		if (!reset_n) begin
			dec_valid  <= 1'b0;
			zf_update  <= 1'b0;
			invalid_op <= 1'b0;
		end else begin
			dec_valid  <= take;
			zf_update  <= take && zf_d && !fault_d;
			invalid_op <= take && fault_d;
		end
	end
endmodule

// [testbench/lld_decode_monitor.sv]
/* decode and busy timing assertions for lld_decode.
   assumes it is bound to lld_decode and watches its ports only */
`timescale 1ns/1ps
module lld_decode_monitor (
	input wire       mclk,
	input wire       reset_n,
	input wire       instr_valid,
	input wire       two_byte,
	input wire [7:0] opcode,
	input wire [7:0] modrm,
	input wire       prot_mode,
	input wire       ready,
	input wire       dec_valid,
	input wire [4:0] dec_class,
	input wire [4:0] dec_clocks,
	input wire       zf_update,
	input wire       invalid_op,
	input wire       busy
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	wire       take = instr_valid && ready;
	wire       one  = take && !two_byte;
	wire       esc  = take && two_byte;
	wire [2:0] rf   = modrm[5:3];
	////////////////////////////////////////////////////////////////
	a_flags_ah_time: assert property (one && opcode == 8'h9F |=> dec_valid &&
		dec_class == 5'h01 && dec_clocks == 5'h02 && !zf_update) else $error("flag copy");
	a_acc_rights_zf: assert property (esc && opcode == 8'h02 && prot_mode |=>
		zf_update && dec_clocks == 5'h09) else $error("access rights");
	a_ea_one_clock: assert property (one && opcode == 8'h8D |=>
		dec_clocks == 5'h01 && ready && !busy && !zf_update) else $error("ea calc");
	a_far_es_mode: assert property (one && opcode == 8'hC4 |=> dec_class == 5'h04 &&
		dec_clocks == ($past(prot_mode) ? 5'h09 : 5'h04)) else $error("far es");
	a_far_ss_prot: assert property (esc && opcode == 8'hB2 && prot_mode |=>
		dec_clocks == 5'h0A) else $error("far ss");
	a_gdt_load: assert property (esc && opcode == 8'h01 && rf == 3'h2 |=>
		dec_class == 5'h08 && dec_clocks == 5'h0A) else $error("global table");
	a_msw_load: assert property (esc && opcode == 8'h01 && rf == 3'h6 |=>
		dec_class == 5'h0A && dec_clocks == 5'h0B) else $error("status word");
	a_task_real_fault: assert property (esc && opcode == 8'h00 && rf == 3'h3 &&
		!prot_mode |=> invalid_op && dec_class == 5'h00) else $error("task fault");
	a_leave_busy: assert property (one && opcode == 8'hC9 |=>
		busy[*3] ##1 (ready && !busy)) else $error("leave span");
	a_loop_time: assert property (one && opcode inside {8'hE0, 8'hE1, 8'hE2} |=>
		dec_clocks == 5'h02 && !zf_update) else $error("loop");
endmodule
bind lld_decode lld_decode_monitor lld_decode_monitor_inst (.mclk, .reset_n, .instr_valid,
	.two_byte, .opcode, .modrm, .prot_mode, .ready, .dec_valid, .dec_class, .dec_clocks,
	.zf_update, .invalid_op, .busy);

// [testbench/tb_lld_decode.sv]
/* self-checking bench for lld_decode.
   assumes the monitor is bound in from its own file */
`timescale 1ns/1ps
module tb_lld_decode;
	reg        mclk = 0;
	reg        reset_n = 0;
	reg        instr_valid = 0;
	reg        two_byte = 0;
	reg  [7:0] opcode = 8'h00;
	reg  [7:0] modrm = 8'h00;
	reg        prot_mode = 0;
	wire       ready;
	wire       dec_valid;
	wire [4:0] dec_class;
	wire [4:0] dec_clocks;
	wire       zf_update;
	wire       invalid_op;
	wire       busy;
	integer    err_count = 0;
	integer    checked = 0;

	lld_decode lld_decode_inst (.mclk, .reset_n, .instr_valid, .two_byte, .opcode, .modrm,
		.prot_mode, .ready, .dec_valid, .dec_class, .dec_clocks, .zf_update, .invalid_op, .busy);

	initial begin
		forever #5 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////
	task chk(input string name, input logic [4:0] exp, input logic [4:0] got);
		checked = checked + 1;
		if (got !== exp) begin
			err_count = err_count + 1;
			$display("unexpected %s: expected %0h seen %0h", name, exp, got);
		end
	endtask
	task finish_test;
		$display("mismatches %0d comparisons %0d", err_count, checked);
		if (err_count == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// drive one instruction, judge the decode and the busy span
	task issue(input logic tb, input logic [7:0] op, input logic [7:0] mr, input logic pm,
		input logic [4:0] ecls, input logic [4:0] eclk, input logic ezf, input logic einv);
		integer k;
		k = 1;
		@(posedge mclk);
		{instr_valid, two_byte, opcode, modrm, prot_mode} <= {1'b1, tb, op, mr, pm};
		@(posedge mclk);
		instr_valid <= 1'b0;
		@(negedge mclk);
		chk("dec_valid", 5'h01, {4'h0, dec_valid});
		chk("dec_class", ecls, dec_class);
		chk("dec_clocks", eclk, dec_clocks);
		chk("zf_update", {4'h0, ezf}, {4'h0, zf_update});
		chk("invalid_op", {4'h0, einv}, {4'h0, invalid_op});
		chk("busy", {4'h0, (eclk > 5'h01)}, {4'h0, busy});
		while (ready !== 1'b1 && k < 40) begin
			@(negedge mclk);
			k = k + 1;
		end
		chk("busy span", (eclk > 5'h01) ? eclk : 5'h01, k[4:0]);
		if (k == 40) begin
			err_count = err_count + 1;
			$display("unexpected ready: expected 1 seen %0b", ready);
			finish_test;
		end
	endtask
	task t_one_byte;
		issue(0, 8'h9F, 8'h00, 1, 5'h01, 5'h02, 0, 0);
		issue(0, 8'h8D, 8'h04, 0, 5'h03, 5'h01, 0, 0);
		issue(0, 8'hC4, 8'h06, 0, 5'h04, 5'h04, 0, 0);
		issue(0, 8'hC4, 8'h06, 1, 5'h04, 5'h09, 0, 0);
		issue(0, 8'hC9, 8'h00, 1, 5'h0E, 5'h04, 0, 0);
		issue(0, 8'hE2, 8'h00, 0, 5'h0F, 5'h02, 0, 0);
		issue(0, 8'hE0, 8'h00, 1, 5'h10, 5'h02, 0, 0);
		issue(0, 8'hE1, 8'h00, 0, 5'h11, 5'h02, 0, 0);
		issue(0, 8'h78, 8'h00, 1, 5'h12, 5'h01, 0, 0);
		issue(0, 8'h88, 8'hC1, 1, 5'h14, 5'h01, 0, 0);
		issue(0, 8'h8B, 8'h06, 0, 5'h15, 5'h01, 0, 0);
	endtask
	task t_escape;
		issue(1, 8'h02, 8'hC1, 1, 5'h02, 5'h09, 1, 0);
		issue(1, 8'hB4, 8'h06, 0, 5'h05, 5'h04, 0, 0);
		issue(1, 8'hB5, 8'h06, 1, 5'h06, 5'h09, 0, 0);
		issue(1, 8'hB2, 8'h06, 1, 5'h07, 5'h0A, 0, 0);
		issue(1, 8'h01, 8'h16, 0, 5'h08, 5'h0A, 0, 0);
		issue(1, 8'h01, 8'h1E, 1, 5'h09, 5'h0A, 0, 0);
		issue(1, 8'h01, 8'hF0, 0, 5'h0A, 5'h0B, 0, 0);
		issue(1, 8'h00, 8'h10, 1, 5'h0B, 5'h08, 0, 0);
		issue(1, 8'h00, 8'h18, 1, 5'h0C, 5'h09, 0, 0);
		issue(1, 8'h03, 8'h06, 1, 5'h0D, 5'h09, 1, 0);
		issue(1, 8'h88, 8'h00, 0, 5'h12, 5'h01, 0, 0);
		issue(1, 8'h8A, 8'h00, 1, 5'h13, 5'h01, 0, 0);
	endtask
	task t_real_faults;
		issue(1, 8'h02, 8'h06, 0, 5'h00, 5'h01, 0, 1);
		issue(1, 8'h00, 8'h10, 0, 5'h00, 5'h01, 0, 1);
		issue(1, 8'h00, 8'h18, 0, 5'h00, 5'h01, 0, 1);
		issue(1, 8'h03, 8'hC0, 0, 5'h00, 5'h01, 0, 1);
	endtask
	// offers held high while the leave is busy must be ignored
	task t_busy_refusal;
		@(posedge mclk);
		{instr_valid, two_byte, opcode, prot_mode} <= {1'b1, 1'b0, 8'hC9, 1'b0};
		@(posedge mclk);
		opcode <= 8'h9F;
		repeat (3) begin
			@(negedge mclk);
			chk("leave class", 5'h0E, dec_class);
		end
		@(posedge mclk);
		instr_valid <= 1'b0;
		@(negedge mclk);
		chk("refused offer", 5'h00, {4'h0, dec_valid});
	endtask
	initial begin
		repeat (11) @(posedge mclk);
		@(negedge mclk);
		chk("reset ready", 5'h00, {4'h0, ready});
		chk("reset busy", 5'h00, {4'h0, busy});
		chk("reset dec_valid", 5'h00, {4'h0, dec_valid});
		chk("reset dec_class", 5'h00, dec_class);
		@(posedge mclk);
		reset_n <= 1'b1;
		repeat (2) @(negedge mclk);
		chk("ready after reset", 5'h01, {4'h0, ready});
		t_one_byte;
		t_escape;
		t_real_faults;
		t_busy_refusal;
		issue(0, 8'h90, 8'h00, 1, 5'h00, 5'h00, 0, 0);
		issue(1, 8'h01, 8'h08, 1, 5'h00, 5'h00, 0, 0);
		issue(1, 8'h00, 8'h20, 1, 5'h00, 5'h00, 0, 0);
		finish_test;
	end
endmodule
